// ---- rtl/aux_timer_capture_reload.sv ----
`timescale 1ns/10ps
// Operation
// - Overflow or down-count match sets overflow flag
// - Overflow flag set only outside baud mode
// - Hardware never clears overflow flag
// - Trigger falling edge sets sticky external flag
// - Down-count overflow also sets external flag
// - Either flag requests interrupt when enabled
// - Receive time base from selected overflow
// - Transmit time base from selected overflow
// - Trigger edge ignored unless enabled, not baud, not down-count
// - Run bit starts, stops, holds count
// - Internal prescaled clock or external falling edges
// - Baud mode ticks every two clocks
// - Baud mode always auto-reloads on overflow
// - Reload on overflow or enabled trigger edge
// - Capture count on enabled trigger edge
// - Capture reset bit clears count after capture
// - Down enable and pin set direction
// - Low capture byte captures, supplies reload
// - High capture byte captures, supplies reload
module aux_timer_capture_reload
  import aux_timer_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // Register bus
  input  wire axil_req_type axil_req_in,
  output axil_rsp_type      axil_rsp_out,
  // Pins and serial port context
  input  wire logic         trigger_pin_in,
  input  wire logic         external_count_pin_in,
  input  wire logic         other_timer_overflow_in,
  input  wire logic [1:0]   serial_mode_in,
  input  wire logic         irq_enable_in,
  // Events out
  output logic              timer_irq_out,
  output logic              own_overflow_out,
  output logic              rx_time_base_out,
  output logic              tx_time_base_out
);

  state_type s;
  state_type n;

  logic        baud;
  logic        capture;
  logic        down;
  logic        trig_fall;
  logic        pin_fall;
  logic [3:0]  div;
  logic        pre_tick;
  logic        tick;
  logic        up_ovf;
  logic        dn_ovf;
  logic        ovf;
  logic        trig_act;
  logic        serial13;
  logic        wr_go;
  logic [7:0]  wr_idx;
  logic        wr_ok;
  logic        ctrl_wr;
  logic        cnt_wr;
  logic        cap_wr;
  logic [7:0]  rd_idx;
  logic        rd_ok;
  logic [7:0]  rd_val;
  logic [15:0] cnt_cur;
  logic [15:0] cap_cur;

  // Mode decode
  assign baud     = s.ctrl[BIT_RCLK] | s.ctrl[BIT_TRANSMIT_CLOCK_SELECT];
  assign capture  = s.ctrl[BIT_CP] & ~baud;
  assign down     = s.down_count_enable & ~capture & ~baud & ~s.trig_s2;
  assign serial13 = serial_mode_in[BIT_SERIAL_ODD];

  // Edges from the second and third sample only
  assign trig_fall = s.trig_prev & ~s.trig_s2;
  assign pin_fall  = s.pin_prev & ~s.pin_s2;

  // Tick source selection
  assign div      = baud ? DIV_BAUD : (s.rate ? DIV_FAST : DIV_SLOW);
  assign pre_tick = (s.pre == div - PRE_STEP);
  assign tick     = s.ctrl[BIT_RUN] &
                    ((baud | ~s.ctrl[BIT_CT]) ? pre_tick : pin_fall);

  // Overflow events
  assign up_ovf = tick & ~down & (s.cnt == COUNT_MAX);
  assign dn_ovf = tick & down & (s.cnt == s.cap);
  assign ovf    = up_ovf | dn_ovf;

  // Trigger acts only when enabled, outside baud and down-count use
  assign trig_act = trig_fall & s.ctrl[BIT_EXEN] & ~baud &
                    ~(s.down_count_enable & ~capture);

  // Write decode
  assign wr_go   = s.aw_full & s.w_full & ~s.bvalid;
  assign wr_idx  = s.aw_addr[IDX_MSB:IDX_LSB];
  assign wr_ok   = (s.aw_addr[ADDR_W-1:IDX_MSB+1] == '0) &
                   (s.aw_addr[IDX_LSB-1:0] == '0) &
                   (wr_idx == IDX_CONTROL || wr_idx == IDX_MODE ||
                    wr_idx == IDX_CAP_LOW || wr_idx == IDX_CAP_HIGH ||
                    wr_idx == IDX_COUNT_LOW || wr_idx == IDX_COUNT_HIGH ||
                    wr_idx == IDX_CLOCK_CONTROL);
  assign ctrl_wr = wr_go & s.w_en & wr_ok & (wr_idx == IDX_CONTROL);
  assign cnt_wr  = wr_go & s.w_en & wr_ok &
                   (wr_idx == IDX_COUNT_LOW || wr_idx == IDX_COUNT_HIGH);
  assign cap_wr  = wr_go & s.w_en & wr_ok &
                   (wr_idx == IDX_CAP_LOW || wr_idx == IDX_CAP_HIGH);
  assign cnt_cur = s.cnt;
  assign cap_cur = s.cap;

  // Read decode
  assign rd_idx = axil_req_in.araddr[IDX_MSB:IDX_LSB];
  always_comb begin
    rd_ok  = (axil_req_in.araddr[ADDR_W-1:IDX_MSB+1] == '0) &
             (axil_req_in.araddr[IDX_LSB-1:0] == '0);
    rd_val = '0;
    case (rd_idx)
      IDX_CONTROL:       rd_val = s.ctrl;
      IDX_MODE: begin
        rd_val[BIT_DOWN_COUNT_ENABLE] = s.down_count_enable;
        rd_val[BIT_CRST] = s.crst;
      end
      IDX_CAP_LOW:       rd_val = s.cap[7:0];
      IDX_CAP_HIGH:      rd_val = s.cap[15:8];
      IDX_COUNT_LOW:     rd_val = s.cnt[7:0];
      IDX_COUNT_HIGH:    rd_val = s.cnt[15:8];
      IDX_CLOCK_CONTROL: rd_val[BIT_RATE] = s.rate;
      default:           rd_ok = 1'b0;
    endcase
  end

  // Next state
  always_comb begin
    n = s;
    // Pin synchronisers
    n.trig_s1   = trigger_pin_in;
    n.trig_s2   = s.trig_s1;
    n.trig_prev = s.trig_s2;
    n.pin_s1    = external_count_pin_in;
    n.pin_s2    = s.pin_s1;
    n.pin_prev  = s.pin_s2;

    // Prescaler runs only for internal ticks
    if (s.ctrl[BIT_RUN] & (baud | ~s.ctrl[BIT_CT])) begin
      n.pre = pre_tick ? PRE_RESET : s.pre + PRE_STEP;
    end else begin
      n.pre = PRE_RESET;
    end

    // Counting; a halted timer keeps its bytes
    if (tick) begin
      if (dn_ovf) begin
        n.cnt = COUNT_MAX;
      end else if (down) begin
        n.cnt = s.cnt - COUNT_STEP;
      end else if (up_ovf & ~capture) begin
        n.cnt = s.cap;
      end else begin
        n.cnt = s.cnt + COUNT_STEP;
      end
    end

    // Trigger edge: capture or reload
    if (trig_act) begin
      if (capture) begin
        n.cap = s.cnt;
        if (s.crst) begin
          n.cnt = COUNT_RESET;
        end
      end else begin
        n.cnt = s.cap;
      end
    end

    // Time bases for the serial port
    n.own_ovf = ovf;
    n.rx_tb   = serial13 & (s.ctrl[BIT_RCLK] ? ovf : other_timer_overflow_in);
    n.tx_tb   = serial13 & (s.ctrl[BIT_TRANSMIT_CLOCK_SELECT] ? ovf : other_timer_overflow_in);

    // Write address and data channels
    if (axil_req_in.awvalid & ~s.aw_full) begin
      n.aw_full = 1'b1;
      n.aw_addr = axil_req_in.awaddr;
    end
    if (axil_req_in.wvalid & ~s.w_full) begin
      n.w_full = 1'b1;
      n.w_data = axil_req_in.wdata[7:0];
      n.w_en   = axil_req_in.wstrb[0];
    end
    if (s.bvalid & axil_req_in.bready) begin
      n.bvalid = 1'b0;
    end

    // Register write; software wins over counting
    if (wr_go) begin
      n.aw_full = 1'b0;
      n.w_full  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
      if (s.w_en & wr_ok) begin
        case (wr_idx)
          IDX_CONTROL:       n.ctrl = s.w_data;
          IDX_MODE: begin
            n.down_count_enable = s.w_data[BIT_DOWN_COUNT_ENABLE];
            n.crst = s.w_data[BIT_CRST];
          end
          IDX_CAP_LOW:       n.cap[7:0]  = s.w_data;
          IDX_CAP_HIGH:      n.cap[15:8] = s.w_data;
          IDX_COUNT_LOW:     n.cnt[7:0]  = s.w_data;
          IDX_COUNT_HIGH:    n.cnt[15:8] = s.w_data;
          IDX_CLOCK_CONTROL: n.rate = s.w_data[BIT_RATE];
          default:           n.rate = s.rate;
        endcase
      end
    end

    // Hardware flag sets win over a clearing write
    if (ovf & ~baud) begin
      n.ctrl[BIT_OVF] = 1'b1;
    end
    if (trig_act | (ovf & s.down_count_enable & ~capture & ~baud)) begin
      n.ctrl[BIT_EXT] = 1'b1;
    end

    // Read channel
    if (s.rvalid & axil_req_in.rready) begin
      n.rvalid = 1'b0;
    end
    if (axil_req_in.arvalid & ~s.rvalid) begin
      n.rvalid = 1'b1;
      n.rdata  = {READ_PAD, rd_val};
      n.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= STATE_RESET;
    end else begin
      s <= n;
    end
  end

  // Outputs
  assign axil_rsp_out.awready = ~s.aw_full;
  assign axil_rsp_out.wready  = ~s.w_full;
  assign axil_rsp_out.bvalid  = s.bvalid;
  assign axil_rsp_out.bresp   = s.bresp;
  assign axil_rsp_out.arready = ~s.rvalid;
  assign axil_rsp_out.rvalid  = s.rvalid;
  assign axil_rsp_out.rdata   = s.rdata;
  assign axil_rsp_out.rresp   = s.rresp;
  assign timer_irq_out    = irq_enable_in & (s.ctrl[BIT_OVF] | s.ctrl[BIT_EXT]);
  assign own_overflow_out = s.own_ovf;
  assign rx_time_base_out = s.rx_tb;
  assign tx_time_base_out = s.tx_tb;

  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence seq_capture_edge;
    trig_act && capture && !cap_wr;
  endsequence

  sequence seq_baud_tick;
    baud && s.ctrl[BIT_RUN] && tick && !ctrl_wr ##1 !ctrl_wr;
  endsequence

  a_overflow_flag_set: assert property (ovf && !baud |=> s.ctrl[BIT_OVF])
    else $error("overflow did not set flag");
  a_baud_no_flag: assert property (
    baud && !s.ctrl[BIT_OVF] && !ctrl_wr |=> !s.ctrl[BIT_OVF])
    else $error("flag set in baud mode");
  a_flag_sticky: assert property (s.ctrl[BIT_OVF] && !ctrl_wr |=> s.ctrl[BIT_OVF])
    else $error("overflow flag cleared by hardware");
  a_capture_copy: assert property (
    seq_capture_edge |=> cap_cur == $past(cnt_cur) && s.ctrl[BIT_EXT])
    else $error("capture value or flag wrong");
  a_reload_value: assert property (
    up_ovf && !capture && !cnt_wr && !trig_act |=> cnt_cur == $past(cap_cur))
    else $error("reload value wrong");
  a_halt_holds: assert property (
    !s.ctrl[BIT_RUN] && !cnt_wr && !trig_act |=> $stable(cnt_cur))
    else $error("halted count moved");
  a_baud_tick_rate: assert property (seq_baud_tick |-> !tick ##1 tick)
    else $error("baud tick not every two clocks");
  a_irq_request: assert property (
    s.ctrl[BIT_EXT] && irq_enable_in |-> timer_irq_out)
    else $error("external flag without interrupt");
  a_rx_own_base: assert property (
    serial13 && s.ctrl[BIT_RCLK] && ovf |=> rx_time_base_out)
    else $error("receive base missed own overflow");
  a_tx_other_base: assert property (
    serial13 && !s.ctrl[BIT_TRANSMIT_CLOCK_SELECT] && other_timer_overflow_in |=> tx_time_base_out)
    else $error("transmit base missed other overflow");
  a_pin_ignored: assert property (!s.ctrl[BIT_EXEN] && !cap_wr |=> $stable(cap_cur))
    else $error("capture changed with trigger disabled");

  // Down count reaching the capture value, no software count write
  sequence seq_down_match;
    dn_ovf && !cnt_wr;
  endsequence

  // Trigger edge in reload mode, no software count write
  sequence seq_trigger_reload;
    trig_act && !capture && !cnt_wr;
  endsequence

  // External flag sources
  a_ext_on_trigger: assert property (trig_act |=> s.ctrl[BIT_EXT])
    else $error("trigger edge did not set external flag");
  a_ext_down_ovf: assert property (
    ovf && s.down_count_enable && !capture && !baud |=> s.ctrl[BIT_EXT])
    else $error("down overflow did not set external flag");

  // Count movement
  a_down_match_max: assert property (seq_down_match |=> cnt_cur == COUNT_MAX)
    else $error("down match did not load all ones");
  a_down_step: assert property (
    tick && down && !dn_ovf && !cnt_wr |=> cnt_cur == $past(cnt_cur) - COUNT_STEP)
    else $error("down step wrong");
  a_up_step: assert property (
    tick && !down && !up_ovf && !cnt_wr && !trig_act |=>
    cnt_cur == $past(cnt_cur) + COUNT_STEP)
    else $error("up step wrong");
  a_ext_pin_tick: assert property (
    s.ctrl[BIT_RUN] && s.ctrl[BIT_CT] && !baud && pin_fall |-> tick)
    else $error("external edge not counted");

  // Capture and reload
  a_capture_clear: assert property (
    seq_capture_edge && s.crst && !cnt_wr |=> cnt_cur == COUNT_RESET)
    else $error("capture reset did not clear count");
  a_trigger_reload: assert property (seq_trigger_reload |=> cnt_cur == $past(cap_cur))
    else $error("trigger reload value wrong");
  a_baud_reload: assert property (
    baud && up_ovf && !cnt_wr |=> cnt_cur == $past(cap_cur))
    else $error("baud overflow did not reload");

  // Serial time bases
  a_rx_other_base: assert property (
    serial13 && !s.ctrl[BIT_RCLK] && other_timer_overflow_in |=> rx_time_base_out)
    else $error("receive base missed other overflow");
  a_tx_own_base: assert property (
    serial13 && s.ctrl[BIT_TRANSMIT_CLOCK_SELECT] && ovf |=> tx_time_base_out)
    else $error("transmit base missed own overflow");
  a_serial_quiet: assert property (
    !serial13 |=> !rx_time_base_out && !tx_time_base_out)
    else $error("time base pulse outside serial modes");

  // Synchroniser chain feeds the edge sample
  a_sync_chain: assert property (1'b1 |=> s.trig_prev == $past(s.trig_s2))
    else $error("trigger sample chain broken");
  a_own_ovf_pulse: assert property (ovf |=> own_overflow_out)
    else $error("overflow pulse missing");

endmodule : aux_timer_capture_reload

// ---- shared/aux_timer_pkg.sv ----
package aux_timer_pkg;

  // Register bus geometry
  localparam int          ADDR_W            = 12;
  localparam int          IDX_LSB           = 2;
  localparam int          IDX_MSB           = 9;

  // Register indexes; the byte address is four times the index
  localparam logic [7:0]  IDX_CONTROL       = 8'hc8;
  localparam logic [7:0]  IDX_MODE          = 8'hc9;
  localparam logic [7:0]  IDX_CAP_LOW       = 8'hca;
  localparam logic [7:0]  IDX_CAP_HIGH      = 8'hcb;
  localparam logic [7:0]  IDX_COUNT_LOW     = 8'hcc;
  localparam logic [7:0]  IDX_COUNT_HIGH    = 8'hcd;
  localparam logic [7:0]  IDX_CLOCK_CONTROL = 8'h8e;

  // Control register bit positions
  localparam int          BIT_OVF           = 7;
  localparam int          BIT_EXT           = 6;
  localparam int          BIT_RCLK          = 5;
  localparam int          BIT_TRANSMIT_CLOCK_SELECT          = 4;
  localparam int          BIT_EXEN          = 3;
  localparam int          BIT_RUN           = 2;
  localparam int          BIT_CT            = 1;
  localparam int          BIT_CP            = 0;

  // Mode and clock control bit positions
  localparam int          BIT_DOWN_COUNT_ENABLE          = 0;
  localparam int          BIT_CRST          = 1;
  localparam int          BIT_RATE          = 5;
  localparam int          BIT_SERIAL_ODD    = 0;

  // Reset and limit values
  localparam logic [7:0]  CONTROL_RESET     = 8'h00;
  localparam logic [15:0] COUNT_RESET       = 16'h0000;
  localparam logic [15:0] COUNT_MAX         = 16'hffff;
  localparam logic [15:0] COUNT_STEP        = 16'h0001;
  localparam logic [23:0] READ_PAD          = 24'h00_0000;

  // Prescale divisors in clocks per tick
  localparam logic [3:0]  DIV_BAUD          = 4'h2;
  localparam logic [3:0]  DIV_SLOW          = 4'hc;
  localparam logic [3:0]  DIV_FAST          = 4'h4;
  localparam logic [3:0]  PRE_STEP          = 4'h1;
  localparam logic [3:0]  PRE_RESET         = 4'h0;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // Bus request bundle from the master
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axil_req_type;

  // Bus answer bundle to the master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_type;

  // Whole state of the timer
  typedef struct packed {
    logic [7:0]        ctrl;
    logic              down_count_enable;
    logic              crst;
    logic              rate;
    logic [15:0]       cap;
    logic [15:0]       cnt;
    logic [3:0]        pre;
    logic              trig_s1;
    logic              trig_s2;
    logic              trig_prev;
    logic              pin_s1;
    logic              pin_s2;
    logic              pin_prev;
    logic              own_ovf;
    logic              rx_tb;
    logic              tx_tb;
    logic              aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_full;
    logic [7:0]        w_data;
    logic              w_en;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } state_type;

  localparam state_type STATE_RESET = '0;

endpackage : aux_timer_pkg

// ---- sim/aux_pin_model.sv ----
`timescale 1ns/10ps
module aux_pin_model (
  // Clock
  input  wire logic clk_in,
  // Pins toward the timer
  output logic      trigger_pin_out,
  output logic      count_pin_out
);
  // Both pins idle high
  initial begin
    trigger_pin_out = 1'b1;
    count_pin_out   = 1'b1;
  end

  // Each level held past the synchroniser depth
  task automatic put(input logic trig, input logic cnt);
    trigger_pin_out <= trig;
    count_pin_out   <= cnt;
    repeat (4) @(posedge clk_in);
  endtask : put
endmodule : aux_pin_model

// ---- sim/aux_timer_capture_reload_test.sv ----
`timescale 1ns/10ps
module aux_timer_capture_reload_test;
  import aux_timer_pkg::*;
  // Control bit masks
  localparam logic [7:0] OVF  = 8'h01 << BIT_OVF;
  localparam logic [7:0] EXT  = 8'h01 << BIT_EXT;
  localparam logic [7:0] RCLK = 8'h01 << BIT_RCLK;
  localparam logic [7:0] EXEN = 8'h01 << BIT_EXEN;
  localparam logic [7:0] RUN  = 8'h01 << BIT_RUN;
  localparam logic [7:0] CT   = 8'h01 << BIT_CT;
  localparam logic [7:0] CP   = 8'h01 << BIT_CP;
  // Bench signals
  logic         clk_in      = 1'b0;
  logic         rst_n_in    = 1'b0;
  logic         irq_en      = 1'b1;
  logic         other_ovf   = 1'b0;
  logic [1:0]   serial_mode = 2'b00;
  logic [2:0]   phase       = 3'h0;
  logic [15:0]  rx_n        = 16'h0000;
  logic [15:0]  tx_n        = 16'h0000;
  logic [15:0]  own_n       = 16'h0000;
  logic [15:0]  rx_0, tx_0, own_0;
  logic [31:0]  seed        = 32'hc043;
  logic         irq, own_ovf, rx_tb, tx_tb, trig, cnt_pin;
  axil_req_type req;
  axil_rsp_type rsp;
  logic [33:0]  notes[$];
  int           compares    = 0;
  int           miscompares = 0;

  // Clock
  always #12.5 clk_in = ~clk_in;

  // Other timer overflow every eight clocks, time base pulse counters
  always @(posedge clk_in) begin
    phase     <= phase + 3'h1;
    other_ovf <= (phase == 3'h0);
    if (rx_tb === 1'b1) rx_n <= rx_n + 16'h0001;
    if (tx_tb === 1'b1) tx_n <= tx_n + 16'h0001;
    if (own_ovf === 1'b1) own_n <= own_n + 16'h0001;
  end

  aux_timer_capture_reload aux_timer_capture_reload_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .axil_req_in(req), .axil_rsp_out(rsp),
    .trigger_pin_in(trig), .external_count_pin_in(cnt_pin),
    .other_timer_overflow_in(other_ovf), .serial_mode_in(serial_mode),
    .irq_enable_in(irq_en), .timer_irq_out(irq), .own_overflow_out(own_ovf),
    .rx_time_base_out(rx_tb), .tx_time_base_out(tx_tb));

  aux_pin_model aux_pin_model_inst (
    .clk_in(clk_in), .trigger_pin_out(trig), .count_pin_out(cnt_pin));

  // Comparisons
  task automatic check_read(input logic [33:0] exp, input logic [33:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : check_read

  task automatic check_level(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : check_level

  function automatic logic [11:0] addr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : addr

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    req.awvalid <= 1'b1;
    req.awaddr  <= addr(idx);
    req.wvalid  <= 1'b1;
    req.wdata   <= {READ_PAD, d};
    do begin
      @(posedge clk_in);
      n++;
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1 && n < 100);
    if (rsp.bvalid !== 1'b1) miscompares++;
  endtask : wr

  // Bus read, expected answer noted first
  task automatic rd(input logic [11:0] a, input logic [33:0] exp);
    int n;
    n = 0;
    notes.push_back(exp);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    do begin
      @(posedge clk_in);
      n++;
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1 && n < 100);
    if (rsp.rvalid !== 1'b1) miscompares++;
  endtask : rd

  task automatic rb(input logic [7:0] idx, input logic [7:0] b);
    rd(addr(idx), {RESP_OKAY, READ_PAD, b});
  endtask : rb

  task automatic rd16(input logic [7:0] lo, input logic [15:0] v);
    rb(lo, v[7:0]);
    rb(lo + 8'h01, v[15:8]);
  endtask : rd16

  task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
    wr(lo + 8'h01, v[15:8]);
    wr(lo, v[7:0]);
  endtask : wr16

  task automatic count_edges(input logic lvl, input int n);
    repeat (n) begin
      aux_pin_model_inst.put(lvl, 1'b0);
      aux_pin_model_inst.put(lvl, 1'b1);
    end
  endtask : count_edges

  // Read answers compared in order
  always @(posedge clk_in) begin
    if (rsp.rvalid === 1'b1) check_read(notes.pop_front(), {rsp.rresp, rsp.rdata});
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    req         = '0;
    req.wstrb   = 4'hf;
    req.bready  = 1'b1;
    req.rready  = 1'b1;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    // Reset values and refused addresses
    rb(IDX_CONTROL, CONTROL_RESET);
    rd16(IDX_COUNT_LOW, COUNT_RESET);
    rd(12'h004, {RESP_SLVERR, 32'h0000_0000});
    rd(12'h322, {RESP_SLVERR, 32'h0000_0000});
    repeat (3) begin
      seed = lfsr(seed);
      wr16(IDX_CAP_LOW, seed[15:0]);
      rd16(IDX_CAP_LOW, seed[15:0]);
    end
    wr(IDX_CLOCK_CONTROL, 8'hff);
    rb(IDX_CLOCK_CONTROL, 8'h01 << BIT_RATE);
    // Overflow on external edges reloads both bytes
    wr16(IDX_COUNT_LOW, 16'hfffe);
    wr(IDX_CONTROL, RUN | CT);
    count_edges(1'b1, 2);
    rd16(IDX_COUNT_LOW, seed[15:0]);
    rb(IDX_CONTROL, OVF | RUN | CT);
    // Stopped timer holds, software clears and sets the flag
    wr(IDX_CONTROL, CT);
    count_edges(1'b1, 2);
    rd16(IDX_COUNT_LOW, seed[15:0]);
    rb(IDX_CONTROL, CT);
    wr(IDX_CONTROL, OVF | CT);
    rb(IDX_CONTROL, OVF | CT);
    // Capture with count reset
    seed = lfsr(seed);
    wr16(IDX_COUNT_LOW, seed[31:16]);
    wr(IDX_MODE, 8'h01 << BIT_CRST);
    wr(IDX_CONTROL, RUN | EXEN | CT | CP);
    aux_pin_model_inst.put(1'b0, 1'b1);
    aux_pin_model_inst.put(1'b1, 1'b1);
    rd16(IDX_CAP_LOW, seed[31:16]);
    rd16(IDX_COUNT_LOW, COUNT_RESET);
    rb(IDX_CONTROL, EXT | RUN | EXEN | CT | CP);
    check_level({15'h0000, irq}, 16'h0001);
    irq_en <= 1'b0;
    @(posedge clk_in);
    check_level({15'h0000, irq}, 16'h0000);
    irq_en <= 1'b1;
    // Trigger ignored while disabled
    wr(IDX_MODE, 8'h00);
    wr16(IDX_COUNT_LOW, seed[15:0]);
    wr(IDX_CONTROL, RUN | CT | CP);
    aux_pin_model_inst.put(1'b0, 1'b1);
    aux_pin_model_inst.put(1'b1, 1'b1);
    rd16(IDX_CAP_LOW, seed[31:16]);
    rd16(IDX_COUNT_LOW, seed[15:0]);
    rb(IDX_CONTROL, RUN | CT | CP);
    // Down count to the capture value, then up with pin high
    seed = lfsr(seed);
    wr(IDX_MODE, 8'h01 << BIT_DOWN_COUNT_ENABLE);
    wr16(IDX_CAP_LOW, seed[15:0]);
    wr16(IDX_COUNT_LOW, seed[15:0]);
    aux_pin_model_inst.put(1'b0, 1'b1);
    wr(IDX_CONTROL, RUN | CT);
    count_edges(1'b0, 1);
    rd16(IDX_COUNT_LOW, COUNT_MAX);
    rb(IDX_CONTROL, OVF | EXT | RUN | CT);
    count_edges(1'b1, 1);
    rd16(IDX_COUNT_LOW, seed[15:0]);
    // Baud generator on the receive side
    serial_mode <= 2'b01;
    wr(IDX_MODE, 8'h00);
    wr16(IDX_CAP_LOW, 16'hfff0);
    wr16(IDX_COUNT_LOW, 16'hfff0);
    wr(IDX_CONTROL, RCLK | RUN | CT | CP);
    repeat (64) @(posedge clk_in);
    rx_0 = rx_n;
    tx_0 = tx_n;
    own_0 = own_n;
    repeat (320) @(posedge clk_in);
    check_level(own_n - own_0, 16'h000a);
    check_level(rx_n - rx_0, 16'h000a);
    check_level(tx_n - tx_0, 16'h0028);
    rb(IDX_CONTROL, RCLK | RUN | CT | CP);
    tally_and_finish();
  end
endmodule : aux_timer_capture_reload_test
